/* File: rtl/sarc_ctrl.sv */
// control logic of an eight channel eight bit sar converter
`timescale 1ns/100ps
module sarc_ctrl (
  input  wire logic                          clk_i,
  input  wire logic                          rst_b_i,
  input  wire logic [sarc_pkg::ADDR_W-1:0]   chan_addr_i,
  input  wire logic                          channel_select_load_i,
  input  wire logic                          start_i,
  input  wire logic                          out_enable_i,
  input  wire logic                          cmp_above_i,
  output logic      [sarc_pkg::NUM_CHAN-1:0] chan_sel_o,
  output logic                               sample_o,
  output logic      [sarc_pkg::DATA_W-1:0]   weight_low_o,
  output logic                               eoc_o,
  output logic      [sarc_pkg::DATA_W-1:0]   data_o,
  output logic      [sarc_pkg::DATA_W-1:0]   data_oe_o,
  input  wire logic [3:0]                    reg_addr_i,
  input  wire logic [7:0]                    reg_wdata_i,
  input  wire logic                          reg_wr_i,
  input  wire logic                          reg_rd_i,
  output logic      [7:0]                    reg_rdata_o,
  output logic                               irq_o
);
  import sarc_pkg::*;

  // input synchronisers
  logic [2:0] ald_s1_q, ald_s2_q;
  logic       st_s1_q, st_s2_q, st_s3_q, oe_s1_q, oe_s2_q, cmp_s1_q, cmp_s2_q;
  logic       ald_prev_q;
  logic [ADDR_W-1:0] adr_s1_q, adr_s2_q;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ald_s1_q <= 3'h0;
      ald_s2_q <= 3'h0;
      adr_s1_q <= '0;
      adr_s2_q <= '0;
      st_s1_q  <= 1'b0;
      st_s2_q  <= 1'b0;
      st_s3_q  <= 1'b0;
      oe_s1_q  <= 1'b0;
      oe_s2_q  <= 1'b0;
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
      ald_prev_q <= 1'b0;
    end else begin
      ald_s1_q <= {2'h0, channel_select_load_i};
      ald_s2_q <= ald_s1_q;
      adr_s1_q <= chan_addr_i;
      adr_s2_q <= adr_s1_q;
      st_s1_q  <= start_i;
      st_s2_q  <= st_s1_q;
      st_s3_q  <= st_s2_q;
      oe_s1_q  <= out_enable_i;
      oe_s2_q  <= oe_s1_q;
      cmp_s1_q <= cmp_above_i;
      cmp_s2_q <= cmp_s1_q;
      ald_prev_q <= ald_s2_q[0];
    end
  end

  wire ald_rise   = ald_s2_q[0] & ~ald_prev_q;
  wire start_rise = st_s2_q & ~st_s3_q;

  // state
  sarc_state_e       state_q, state_d;
  logic [5:0]        cnt_q;
  logic [2:0]        bit_q;
  logic [DATA_W-1:0] sar_q, latch_q, wlow_q;
  logic [ADDR_W-1:0] chan_q;
  logic              eoc_q;
  logic [7:0]        stat_q, mask_q, rdata_q;
  logic              irq_q;

  wire [5:0] cnt_d     = cnt_q + 6'h1;
  wire       samp_end  = (state_q == SARC_SAMPLE) && (cnt_q == 6'(SAMPLE_CYCLES - 1));
  // whole conversion, sampling included, spans CONV_CYCLES clocks
  wire       conv_end  = (state_q == SARC_CONVERT) &&
                         (cnt_q == 6'(CONV_CYCLES - SAMPLE_CYCLES - 1));
  wire       trial_tic = (state_q == SARC_CONVERT) && (cnt_q[1:0] == 2'h3);
  wire       busy      = (state_q == SARC_SAMPLE) || (state_q == SARC_CONVERT);
  wire       abort_ev  = start_rise & busy;
  wire [DATA_W-1:0] bit_oh = 8'h01 << bit_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      SARC_IDLE:    state_d = state_q;
      SARC_SAMPLE:  if (samp_end) state_d = SARC_CONVERT;
      SARC_CONVERT: if (conv_end) state_d = SARC_DONE;
      SARC_DONE:    state_d = state_q;
      default:      state_d = SARC_IDLE;
    endcase
    if (start_rise) state_d = SARC_SAMPLE;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_q <= SARC_IDLE;
      cnt_q   <= 6'h0;
      bit_q   <= 3'h7;
      sar_q   <= RESULT_RST;
      wlow_q  <= 8'h00;
      latch_q <= RESULT_RST;
      chan_q  <= '0;
      eoc_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      if (ald_rise) chan_q <= adr_s2_q;
      if (start_rise) begin
        cnt_q   <= 6'h0;
        bit_q   <= 3'h7;
        sar_q   <= 8'h00;
        wlow_q  <= 8'h00;
        latch_q <= RESULT_RST;
        eoc_q   <= 1'b0;
      end else begin
        if (samp_end) begin
          cnt_q  <= 6'h0;
          wlow_q <= 8'h80;
        end else if (state_q == SARC_CONVERT) begin
          cnt_q <= cnt_d;
        end else if (state_q == SARC_SAMPLE) begin
          cnt_q <= cnt_d;
        end
        if (trial_tic) begin
          // above threshold keeps the weight low, else releases it
          sar_q  <= cmp_s2_q ? (sar_q | bit_oh) : sar_q;
          wlow_q <= (cmp_s2_q ? wlow_q : (wlow_q & ~bit_oh))
                    | ((bit_q != 3'h0) ? (bit_oh >> 1) : 8'h00);
          bit_q  <= bit_q - 3'h1;
        end
        if (conv_end) begin
          // last trial falls on this edge, so fold its decision in
          latch_q <= cmp_s2_q ? (sar_q | bit_oh) : sar_q;
          eoc_q   <= 1'b1;
          wlow_q  <= 8'h00;
        end
      end
    end
  end

  // register port and interrupts
  wire [7:0] ev      = {6'h00, abort_ev, conv_end & ~start_rise};
  wire       wr_stat = reg_wr_i && (reg_addr_i == OFF_STATUS);
  wire       wr_mask = reg_wr_i && (reg_addr_i == OFF_MASK);
  wire [7:0] stat_d  = (stat_q & ~(wr_stat ? reg_wdata_i : 8'h00)) | ev;
  wire [7:0] rd_mux  = (reg_addr_i == OFF_STATUS) ? stat_q :
                       (reg_addr_i == OFF_MASK)   ? mask_q :
                       (reg_addr_i == OFF_RESULT) ? latch_q :
                       (reg_addr_i == OFF_CHAN)   ? {4'h0, eoc_q, chan_q} : 8'h00;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      stat_q  <= 8'h00;
      mask_q  <= MASK_RST;
      rdata_q <= 8'h00;
      irq_q   <= 1'b0;
    end else begin
      stat_q  <= stat_d;
      if (wr_mask) mask_q <= reg_wdata_i;
      rdata_q <= reg_rd_i ? rd_mux : 8'h00;
      irq_q   <= |(stat_d & mask_q);
    end
  end

  // output flops
  logic [NUM_CHAN-1:0] sel_q;
  logic [DATA_W-1:0]   dout_q, doe_q;
  logic                samp_q;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sel_q  <= 8'h01;
      dout_q <= 8'h00;
      doe_q  <= 8'h00;
      samp_q <= 1'b0;
    end else begin
      sel_q  <= 8'h01 << chan_q;
      dout_q <= oe_s2_q ? latch_q : 8'h00;
      doe_q  <= {DATA_W{oe_s2_q}};
      samp_q <= state_d == SARC_SAMPLE;
    end
  end

  assign chan_sel_o   = sel_q;
  assign sample_o     = samp_q;
  assign weight_low_o = wlow_q;
  assign eoc_o        = eoc_q;
  assign data_o       = dout_q;
  assign data_oe_o    = doe_q;
  assign reg_rdata_o  = rdata_q;
  assign irq_o        = irq_q;

  a_start_clears_eoc: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    start_rise |=> !eoc_o)
    else $error("eoc not withdrawn after start");
  a_start_clears_latch: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    start_rise |=> (latch_q == 8'h00))
    else $error("latch not cleared at start");
  a_sample_length: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(state_q == SARC_SAMPLE) && cnt_q == 6'h0 |-> ##31 (samp_end || start_rise || $past(start_rise)))
    else $error("sample phase length wrong");
  a_first_weight: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    samp_end && !start_rise |=> (weight_low_o == 8'h80))
    else $error("first trial not weight 128");
  a_abort_no_eoc: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    abort_ev |=> !eoc_q && (latch_q == 8'h00))
    else $error("aborted result presented");
  a_eoc_latch: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    conv_end && !start_rise |=> eoc_q &&
      (latch_q == $past(sar_q | (cmp_s2_q ? bit_oh : 8'h00))))
    else $error("eoc without latched result");
  a_eoc_holds: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    eoc_q && !start_rise |=> eoc_q)
    else $error("eoc dropped before start");
  a_chan_decode: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $onehot(chan_sel_o))
    else $error("channel select not one hot");
  a_oe_follows: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !oe_s2_q |=> (data_oe_o == 8'h00))
    else $error("data driven without enable");
  a_bit_set: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    trial_tic && cmp_s2_q && !start_rise |=> sar_q[$past(bit_q)])
    else $error("result bit not set when above");
endmodule // sarc_ctrl

/* File: rtl/sarc_pkg.sv */
// constants and types for the eight channel sar converter control
package sarc_pkg;
  localparam int unsigned NUM_CHAN      = 8;
  localparam int unsigned ADDR_W        = 3;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned SAMPLE_CYCLES = 32;
  localparam int unsigned CONV_CYCLES   = 64;
  localparam logic [7:0]  RESULT_RST    = 8'h00;
  localparam logic [7:0]  MASK_RST      = 8'h00;
  // register port offsets
  localparam logic [3:0]  OFF_STATUS    = 4'h0;
  localparam logic [3:0]  OFF_MASK      = 4'h1;
  localparam logic [3:0]  OFF_RESULT    = 4'h2;
  localparam logic [3:0]  OFF_CHAN      = 4'h3;
  localparam int unsigned IRQ_DONE      = 0;
  localparam int unsigned IRQ_ABORT     = 1;
  typedef enum logic [1:0] {SARC_IDLE, SARC_SAMPLE, SARC_CONVERT, SARC_DONE} sarc_state_e;
endpackage

/* File: tb/sarc_front.sv */
// comparator and analog input model facing the sar control
`timescale 1ns/100ps
module sarc_front (
  input  wire logic [7:0]  chan_sel_i,
  input  wire logic [7:0]  weight_low_i,
  input  wire logic [63:0] vin_i,
  output logic             cmp_above_o
);
  logic [7:0] v;
  always_comb begin
    v = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (chan_sel_i[i]) v = vin_i[i*8+:8];
    end
  end
  // node above trip point while trial code fits under input
  assign cmp_above_o = v >= weight_low_i;
endmodule // sarc_front

/* File: tb/tb_sarc_ctrl.sv */
// bench for the sar converter control
`timescale 1ns/100ps
module tb_sarc_ctrl;
  import sarc_pkg::*;
  logic        clk = 0, rst_b = 0, ld = 0, st = 0, oe = 0, wr = 0, rd = 0, run = 0;
  logic        cmp, eoc, smp, irq;
  logic [2:0]  ad = 0;
  logic [3:0]  ra = 0;
  logic [7:0]  wd = 0, rdat, dat, doe, wl, sel;
  logic [63:0] vin = 64'h01a5_7f80_fe40_ff00;
  int          fails = 0, comparisons = 0, k, t0;
  initial forever #2 clk = ~clk;
  sarc_ctrl u_dut (.clk_i(clk), .rst_b_i(rst_b), .chan_addr_i(ad),
    .channel_select_load_i(ld), .start_i(st | (run & eoc)), .out_enable_i(oe),
    .cmp_above_i(cmp), .chan_sel_o(sel), .sample_o(smp), .weight_low_o(wl),
    .eoc_o(eoc), .data_o(dat), .data_oe_o(doe), .reg_addr_i(ra), .reg_wdata_i(wd),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .irq_o(irq));
  sarc_front u_fe (.chan_sel_i(sel), .weight_low_i(wl), .vin_i(vin), .cmp_above_o(cmp));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    ra <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic rreg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    ra <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdat, e);
  endtask
  task automatic wt(ref logic s, input logic v);
    k = 0;
    while (s !== v) begin
      @(negedge clk);
      k++;
      if (k > 300) begin
        fails++;
        wrap_up();
      end
    end
  endtask
  // start held three clocks so the synchroniser sees it
  task automatic go;
    @(posedge clk);
    st <= 1'b1;
    t0 = $time;
    repeat (3) @(posedge clk);
    st <= 1'b0;
  endtask
  task automatic conv(input logic [2:0] c);
    @(posedge clk);
    ad <= c;
    ld <= 1'b1;
    repeat (3) @(posedge clk);
    ld <= 1'b0;
    repeat (4) @(negedge clk);
    chk(sel, 8'h01 << c);
    go();
    wt(eoc, 1'b0);
    chk({7'h00, k <= 8}, 8'h01);
    @(posedge clk);
    oe <= 1'b1;
    repeat (6) @(negedge clk);
    chk(dat, 8'h00);
    chk(doe, 8'hff);
    wt(smp, 1'b0);
    chk(wl, 8'h80);
    wt(eoc, 1'b1);
    k = ($time - t0) / 4;
    chk({7'h00, k >= CONV_CYCLES && k <= CONV_CYCLES + 6}, 8'h01);
    @(negedge clk);
    chk(dat, vin[c*8+:8]);
    rreg(OFF_RESULT, vin[c*8+:8]);
    @(posedge clk);
    oe <= 1'b0;
    repeat (6) @(negedge clk);
    chk(doe, 8'h00);
    chk(dat, 8'h00);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(negedge clk);
    chk(sel, 8'h01);
    chk({eoc, irq}, 8'h00);
    rreg(OFF_MASK, MASK_RST);
    rreg(OFF_RESULT, RESULT_RST);
    rreg(4'h9, 8'h00);
    for (int i = 0; i < 8; i++) conv(3'(i));
    $display("test channels done");
    rreg(OFF_STATUS, 8'h01);
    chk({7'h00, irq}, 8'h00);
    wreg(OFF_MASK, 8'h03);
    chk({7'h00, irq}, 8'h01);
    wreg(OFF_STATUS, 8'h01);
    chk({7'h00, irq}, 8'h00);
    $display("test interrupt done");
    go();
    repeat (40) @(posedge clk);
    go();
    wt(eoc, 1'b1);
    k = ($time - t0) / 4;
    chk({7'h00, k >= CONV_CYCLES && k <= CONV_CYCLES + 6}, 8'h01);
    rreg(OFF_STATUS, 8'h03);
    chk({7'h00, irq}, 8'h01);
    wreg(OFF_STATUS, 8'h03);
    $display("test abort done");
    @(posedge clk);
    run <= 1'b1;
    go();
    wt(eoc, 1'b0);
    wt(eoc, 1'b1);
    wt(eoc, 1'b0);
    wt(eoc, 1'b1);
    chk(dat, 8'h00);
    $display("test free run done");
    wrap_up();
  end
endmodule // tb_sarc_ctrl
